/* core/isd_pkg.sv */
/*
 Shared types, opcode map and reset values of the instruction execute core.
 Assumes a single clock domain and an outside fetch unit that presents whole instructions.
*/
package isd_pkg;

	// ==========================================================
	// Carriers
	typedef struct packed {
		logic n;
		logic c;
		logic v;
		logic z;
	} isd_flags_t;

	typedef struct packed {
		logic [15:0] imm;
		logic [3:0] rs;
		logic [3:0] rd;
		logic [7:0] op;
	} isd_ins_t;

	typedef struct packed {
		logic [7:0] seg;
		logic [15:0] ip;
	} isd_pc_t;

	typedef struct packed {
		logic [2:0] left;
		logic uninterruptible_prefix;
		logic reg_ext;
		logic page_en;
		logic seg_en;
		logic [15:0] base;
	} isd_ext_t;

	typedef struct packed {
		logic [15:0][15:0] general_register;
		logic [7:0][15:0] stk;
		logic [2:0] sp;
		isd_pc_t pc;
		isd_flags_t fl;
		logic [31:0] prod;
		isd_ext_t ext;
		logic [15:0] dbg;
	} isd_state_t;

	localparam isd_state_t RST_STATE = '0;

	// ==========================================================
	// Opcode layout
	localparam logic [2:0] GRP_ARITH = 3'h0;
	localparam logic [2:0] GRP_CMP = 3'h1;
	localparam logic [2:0] GRP_EXT = 3'h2;
	localparam logic [2:0] GRP_LONG = 3'h4;
	localparam logic [2:0] GRP_PREFIX = 3'h7;
	localparam int OPB_IMM = 4;
	localparam int OPB_BYTE = 3;
	localparam int OPB_SUB = 2;
	localparam int OPB_CARRY = 1;
	localparam int OPB_INC = 1;
	localparam int OPB_TWO = 0;
	localparam int OPB_ZERO = 0;

	localparam logic [7:0] OP_MULTIPLY_S = 8'h60;
	localparam logic [7:0] OP_MULTIPLY_U = 8'h61;
	localparam logic [7:0] OP_DIVIDE_S = 8'h62;
	localparam logic [7:0] OP_DIVIDE_U = 8'h63;
	localparam logic [7:0] OP_LONG_DIVIDE_S = 8'h64;
	localparam logic [7:0] OP_LONG_DIVIDE_U = 8'h65;
	localparam logic [7:0] OP_ONES_W = 8'h66;
	localparam logic [7:0] OP_ONES_B = 8'h67;
	localparam logic [7:0] OP_TWOS_W = 8'h68;
	localparam logic [7:0] OP_TWOS_B = 8'h69;
	localparam logic [7:0] OP_NORM_COUNT = 8'h6A;
	localparam logic [7:0] OP_SHIFT_LEFT = 8'h6B;
	localparam logic [7:0] OP_SHIFT_RIGHT = 8'h6C;
	localparam logic [7:0] OP_ROTATE_LEFT = 8'h6D;
	localparam logic [7:0] OP_ROTATE_RIGHT = 8'h6E;
	localparam logic [7:0] OP_SIGN_SHIFT = 8'h6F;
	localparam logic [7:0] OP_BIT_COPY = 8'h80;
	localparam logic [7:0] OP_BIT_COPY_INV = 8'h81;
	localparam logic [7:0] OP_BIT_AND = 8'h82;
	localparam logic [7:0] OP_BIT_OR = 8'h83;
	localparam logic [7:0] OP_BIT_XOR = 8'h84;
	localparam logic [7:0] OP_BIT_COMPARE = 8'h85;
	localparam logic [7:0] OP_FIELD_HIGH = 8'h86;
	localparam logic [7:0] OP_FIELD_LOW = 8'h87;
	localparam logic [7:0] OP_IF_ONE = 8'h88;
	localparam logic [7:0] OP_IF_ONE_CLR = 8'h89;
	localparam logic [7:0] OP_IF_ZERO = 8'h8A;
	localparam logic [7:0] OP_IF_ZERO_SET = 8'h8B;
	localparam logic [7:0] OP_FAR_JUMP = 8'h8C;
	localparam logic [7:0] OP_FAR_CALL = 8'h8D;
	localparam logic [7:0] OP_PUSH_CALL = 8'h8E;
	localparam logic [7:0] OP_CONTEXT = 8'h8F;
	localparam logic [7:0] OP_POWER_DOWN = 8'h90;
	localparam logic [7:0] OP_NEAR_RETURN = 8'hA0;
	localparam logic [7:0] OP_NEAR_RETURN_POP = 8'hA1;
	localparam logic [7:0] OP_TRAP = 8'hA2;
	localparam logic [7:0] OP_NOP = 8'hA3;

	localparam logic [2:0] PFX_UNINTERRUPTIBLE_PREFIX = 3'h0;
	localparam logic [2:0] PFX_REG = 3'h1;
	localparam logic [2:0] PFX_PAGE = 3'h2;
	localparam logic [2:0] PFX_PAGE_REG = 3'h3;
	localparam logic [2:0] PFX_SEG = 3'h4;
	localparam logic [2:0] PFX_SEG_REG = 3'h5;

	localparam logic [7:0] TRAP_SEG = 8'h00;
	localparam logic [15:0] LEN_SHORT = 16'h0002;
	localparam logic [15:0] LEN_LONG = 16'h0004;

	// ==========================================================
	// Decode helpers
	function automatic logic imm_form(input logic [7:0] op);
		logic [2:0] g;
		g = op[7:5];
		return op[OPB_IMM] && (g == GRP_ARITH || g == GRP_CMP || g == GRP_EXT || g == GRP_PREFIX);
	endfunction

	function automatic logic [15:0] ins_len(input logic [7:0] op);
		return (op[7:5] == GRP_LONG || imm_form(op)) ? LEN_LONG : LEN_SHORT;
	endfunction

endpackage

/* core/isd_alu.sv */
/*
 Combinational word/byte arithmetic, shift, normalise and extend unit.
 Assumes operands already selected by the core; result is registered there.
*/
`timescale 1ns/10ps
module isd_alu (
	input wire logic [7:0] op,
	input wire logic [15:0] a,
	input wire logic [15:0] b,
	input wire logic cin,
	output logic [15:0] res,
	output isd_pkg::isd_flags_t fl
);
	always_comb begin
		logic [16:0] sw;
		logic [8:0] sb;
		logic [15:0] x;
		logic [15:0] y;
		logic [31:0] t;
		logic [3:0] idx;
		logic byt;
		logic sub;
		logic cy;
		logic ys;
		sw = '0;
		sb = '0;
		x = a;
		y = b;
		t = '0;
		idx = '0;
		byt = op[isd_pkg::OPB_BYTE] && op[7:5] == isd_pkg::GRP_ARITH;
		sub = op[isd_pkg::OPB_SUB] || op[7:5] == isd_pkg::GRP_CMP;
		cy = op[isd_pkg::OPB_CARRY] && op[7:5] == isd_pkg::GRP_ARITH && cin;
		res = a;
		fl = '0;
		if (op == isd_pkg::OP_TWOS_W || op == isd_pkg::OP_TWOS_B) begin
			x = '0;
			y = a;
			sub = 1'b1;
			byt = op[0];
		end
		// ==========================================================
		// Shared adder: add, subtract, compare and negate
		sw = sub ? {1'b0, x} - {1'b0, y} - 17'(cy) : {1'b0, x} + {1'b0, y} + 17'(cy);
		sb = sub ? {1'b0, x[7:0]} - {1'b0, y[7:0]} - 9'(cy) : {1'b0, x[7:0]} + {1'b0, y[7:0]} + 9'(cy);
		ys = byt ? y[7] ^ sub : y[15] ^ sub;
		unique case (op) inside
			[8'h00:8'h3F], isd_pkg::OP_TWOS_W, isd_pkg::OP_TWOS_B: begin
				// Byte forms keep the upper byte of the register, negate included
				res = byt ? {a[15:8], sb[7:0]} : sw[15:0];
				fl.c = byt ? sb[8] : sw[16];
				fl.v = byt ? (x[7] == ys) && (sb[7] != x[7]) : (x[15] == ys) && (sw[15] != x[15]);
			end
			isd_pkg::OP_ONES_W: res = ~a;
			isd_pkg::OP_ONES_B: res = {a[15:8], ~a[7:0]};
			isd_pkg::OP_NORM_COUNT: begin
				for (int i = 0; i < 16; i++) begin
					if (a[i]) idx = 4'(i);
				end
				res = (a == '0) ? '0 : {12'h000, 4'hF - idx};
			end
			isd_pkg::OP_SHIFT_LEFT: begin
				t = {16'h0000, a} << b[3:0];
				res = t[15:0];
				fl.c = t[16];
			end
			isd_pkg::OP_SHIFT_RIGHT: begin
				t = {a, 16'h0000} >> b[3:0];
				res = t[31:16];
				fl.c = t[15];
			end
			isd_pkg::OP_ROTATE_LEFT: begin
				t = {a, a} << b[3:0];
				res = t[31:16];
				fl.c = res[0];
			end
			isd_pkg::OP_ROTATE_RIGHT: begin
				t = {a, a} >> b[3:0];
				res = t[15:0];
				fl.c = res[15];
			end
			isd_pkg::OP_SIGN_SHIFT: begin
				t = $signed({a, 16'h0000}) >>> b[3:0];
				res = t[31:16];
				fl.c = t[15];
			end
			[8'h40:8'h5F]: begin
				// Zero or sign fill of the upper byte
				res = op[isd_pkg::OPB_ZERO] ? {8'h00, b[7:0]} : {{8{b[7]}}, b[7:0]};
			end
			default: res = a;
		endcase
		fl.z = byt ? res[7:0] == 8'h00 : res == 16'h0000;
		fl.n = byt ? res[7] : res[15];
	end
endmodule // isd_alu

/* core/isd_core.sv */
/*
 Instruction execute core: register file, multiply/divide register, stack,
 bit operations, branches, traps and addressing prefixes.
 Assumes one decoded instruction word per valid cycle from an outside fetch unit,
 which follows the program counter output.
*/
// Functional notes
// - Add/subtract word or byte, optional carry
// - Signed or unsigned 16x16 register multiply
// - Divide low half by register, 16/16
// - Long divide full result register by register
// - Ones and twos complement, word and byte
// - Copy bit, plain or inverted
// - AND, OR, XOR of two bits
// - Bit compare sets flags only
// - Masked immediate update of one byte
// - Compare, then decrement register by 1/2
// - Compare, then increment register by 1/2
// - Normalise count written to register
// - Shifts, rotates, sign-filling right shift
// - Byte to word, sign or zero fill
// - Jump if bit one, optionally clearing
// - Jump if bit zero, optionally setting
// - Far jump and far call
// - Push register, then call absolute
// - Push register, then load operand
// - Near return, optionally popping register
// - Trap via number in the rs and rd fields
// - Power-down opcode is a four-byte no-op
`timescale 1ns/10ps
module isd_core (
	input wire logic clk,
	input wire logic rst,
	input wire logic ins_valid,
	input wire isd_pkg::isd_ins_t ins,
	input wire logic [3:0] dbg_sel,
	output isd_pkg::isd_pc_t pc,
	output isd_pkg::isd_flags_t flags,
	output logic [31:0] muldiv_result_reg,
	output logic [15:0] dbg_data,
	output isd_pkg::isd_ext_t ext,
	output logic [2:0] stack_depth
);
	isd_pkg::isd_state_t s_q;
	isd_pkg::isd_state_t s_d;
	logic [7:0] op;
	logic [2:0] grp;
	logic [15:0] ra;
	logic [15:0] rb;
	logic [15:0] alu_res;
	isd_pkg::isd_flags_t alu_fl;

	assign op = ins.op;
	assign grp = op[7:5];
	assign ra = (op == isd_pkg::OP_NORM_COUNT) ? s_q.general_register[ins.rs] : s_q.general_register[ins.rd];
	assign rb = isd_pkg::imm_form(op) ? ins.imm : s_q.general_register[ins.rs];

	isd_alu u_alu (
		.op(op),
		.a(ra),
		.b(rb),
		.cin(s_q.fl.c),
		.res(alu_res),
		.fl(alu_fl)
	);

	// ==========================================================
	// Next state
	always_comb begin
		logic [15:0] next_ip;
		logic [15:0] tgt;
		logic [15:0] w;
		logic [31:0] num;
		logic [31:0] den;
		logic [31:0] quo;
		logic [31:0] rem;
		logic sgn;
		logic bs;
		logic bd;
		logic bt;
		next_ip = s_q.pc.ip + isd_pkg::ins_len(op);
		tgt = next_ip + ins.imm;
		w = s_q.general_register[ins.rd];
		sgn = ~op[0];
		num = '0;
		den = '0;
		quo = '0;
		rem = '0;
		bs = s_q.general_register[ins.rs][ins.imm[7:4]];
		bd = s_q.general_register[ins.rd][ins.imm[3:0]];
		bt = s_q.general_register[ins.rd][ins.rs];
		s_d = s_q;
		s_d.dbg = s_q.general_register[dbg_sel];
		if (ins_valid) begin
			s_d.pc.ip = next_ip;
			if (s_q.ext.left != 3'h0) begin
				// A prefix covers only the next few instructions
				s_d.ext.left = s_q.ext.left - 3'h1;
				if (s_q.ext.left == 3'h1) s_d.ext = '0;
			end
			if (grp == isd_pkg::GRP_ARITH || grp == isd_pkg::GRP_EXT) begin
				s_d.general_register[ins.rd] = alu_res;
				s_d.fl = alu_fl;
			end else if (grp == isd_pkg::GRP_CMP) begin
				s_d.fl = alu_fl;
				w = op[isd_pkg::OPB_TWO] ? 16'h0002 : 16'h0001;
				if (op[isd_pkg::OPB_INC]) begin
					s_d.general_register[ins.rd] = ra + w;
				end else begin
					s_d.general_register[ins.rd] = ra - w;
				end
			end else if (grp == isd_pkg::GRP_PREFIX) begin
				s_d.ext = '0;
				s_d.ext.left = {1'b0, ins.rd[1:0]} + 3'h1;
				s_d.ext.base = rb;
				unique case (op[2:0])
					isd_pkg::PFX_UNINTERRUPTIBLE_PREFIX: s_d.ext.uninterruptible_prefix = 1'b1;
					isd_pkg::PFX_REG: s_d.ext.reg_ext = 1'b1;
					isd_pkg::PFX_PAGE: s_d.ext.page_en = 1'b1;
					isd_pkg::PFX_PAGE_REG: begin
						s_d.ext.page_en = 1'b1;
						s_d.ext.reg_ext = 1'b1;
					end
					isd_pkg::PFX_SEG: s_d.ext.seg_en = 1'b1;
					isd_pkg::PFX_SEG_REG: begin
						s_d.ext.seg_en = 1'b1;
						s_d.ext.reg_ext = 1'b1;
					end
					default: s_d.ext = '0;
				endcase
			end else begin
				unique case (op)
					isd_pkg::OP_MULTIPLY_S: begin
						s_d.prod = $signed({{16{ra[15]}}, ra}) * $signed({{16{rb[15]}}, rb});
					end
					isd_pkg::OP_MULTIPLY_U: s_d.prod = {16'h0000, ra} * {16'h0000, rb};
					isd_pkg::OP_DIVIDE_S, isd_pkg::OP_DIVIDE_U,
					isd_pkg::OP_LONG_DIVIDE_S, isd_pkg::OP_LONG_DIVIDE_U: begin
						if (op[2]) begin
							num = s_q.prod;
						end else begin
							num = {{16{sgn & s_q.prod[15]}}, s_q.prod[15:0]};
						end
						den = {{16{sgn & rb[15]}}, rb};
						if (rb == 16'h0000) begin
							// Divide by zero flags overflow and keeps the old result
							s_d.fl.v = 1'b1;
						end else begin
							// A mixed ?: would turn the signed divide unsigned, so keep them apart
							if (sgn) begin
								quo = $signed(num) / $signed(den);
								rem = $signed(num) % $signed(den);
							end else begin
								quo = num / den;
								rem = num % den;
							end
							s_d.prod = {rem[15:0], quo[15:0]};
							s_d.fl = '0;
							s_d.fl.z = quo[15:0] == 16'h0000;
							s_d.fl.n = quo[15];
						end
					end
					isd_pkg::OP_ONES_W, isd_pkg::OP_ONES_B, isd_pkg::OP_TWOS_W,
					isd_pkg::OP_TWOS_B, isd_pkg::OP_NORM_COUNT, isd_pkg::OP_SHIFT_LEFT,
					isd_pkg::OP_SHIFT_RIGHT, isd_pkg::OP_ROTATE_LEFT,
					isd_pkg::OP_ROTATE_RIGHT, isd_pkg::OP_SIGN_SHIFT: begin
						s_d.general_register[ins.rd] = alu_res;
						s_d.fl = alu_fl;
					end
					isd_pkg::OP_BIT_COPY: s_d.general_register[ins.rd][ins.imm[3:0]] = bs;
					isd_pkg::OP_BIT_COPY_INV: s_d.general_register[ins.rd][ins.imm[3:0]] = ~bs;
					isd_pkg::OP_BIT_AND: s_d.general_register[ins.rd][ins.imm[3:0]] = bd & bs;
					isd_pkg::OP_BIT_OR: s_d.general_register[ins.rd][ins.imm[3:0]] = bd | bs;
					isd_pkg::OP_BIT_XOR: s_d.general_register[ins.rd][ins.imm[3:0]] = bd ^ bs;
					isd_pkg::OP_BIT_COMPARE: begin
						s_d.fl.c = bs & bd;
						s_d.fl.v = bs | bd;
						s_d.fl.n = bs ^ bd;
						s_d.fl.z = ~bs;
					end
					isd_pkg::OP_FIELD_HIGH: begin
						w[15:8] = (w[15:8] & ~ins.imm[7:0]) | (ins.imm[15:8] & ins.imm[7:0]);
						s_d.general_register[ins.rd] = w;
					end
					isd_pkg::OP_FIELD_LOW: begin
						w[7:0] = (w[7:0] & ~ins.imm[7:0]) | (ins.imm[15:8] & ins.imm[7:0]);
						s_d.general_register[ins.rd] = w;
					end
					isd_pkg::OP_IF_ONE, isd_pkg::OP_IF_ONE_CLR: begin
						if (bt) begin
							s_d.pc.ip = tgt;
							if (op[0]) s_d.general_register[ins.rd][ins.rs] = 1'b0;
						end
					end
					isd_pkg::OP_IF_ZERO, isd_pkg::OP_IF_ZERO_SET: begin
						if (!bt) begin
							s_d.pc.ip = tgt;
							if (op[0]) s_d.general_register[ins.rd][ins.rs] = 1'b1;
						end
					end
					isd_pkg::OP_FAR_JUMP: begin
						s_d.pc = {ins.rs, ins.rd, ins.imm};
					end
					isd_pkg::OP_FAR_CALL: begin
						s_d.stk[s_d.sp] = {8'h00, s_q.pc.seg};
						s_d.sp = s_d.sp + 3'h1;
						s_d.stk[s_d.sp] = next_ip;
						s_d.sp = s_d.sp + 3'h1;
						s_d.pc = {ins.rs, ins.rd, ins.imm};
					end
					isd_pkg::OP_PUSH_CALL: begin
						s_d.stk[s_d.sp] = ra;
						s_d.sp = s_d.sp + 3'h1;
						s_d.stk[s_d.sp] = next_ip;
						s_d.sp = s_d.sp + 3'h1;
						s_d.pc.ip = ins.imm;
					end
					isd_pkg::OP_CONTEXT: begin
						s_d.stk[s_d.sp] = ra;
						s_d.sp = s_d.sp + 3'h1;
						s_d.general_register[ins.rd] = ins.imm;
					end
					isd_pkg::OP_NEAR_RETURN, isd_pkg::OP_NEAR_RETURN_POP: begin
						s_d.sp = s_d.sp - 3'h1;
						s_d.pc.ip = s_d.stk[s_d.sp];
						if (op[0]) begin
							s_d.sp = s_d.sp - 3'h1;
							s_d.general_register[ins.rd] = s_d.stk[s_d.sp];
						end
					end
					isd_pkg::OP_TRAP: begin
						s_d.stk[s_d.sp] = {12'h000, s_q.fl};
						s_d.sp = s_d.sp + 3'h1;
						s_d.stk[s_d.sp] = {8'h00, s_q.pc.seg};
						s_d.sp = s_d.sp + 3'h1;
						s_d.stk[s_d.sp] = next_ip;
						s_d.sp = s_d.sp + 3'h1;
						s_d.pc = {isd_pkg::TRAP_SEG, 7'h00, ins.rs[2:0], ins.rd, 2'b00};
					end
					// Decoded for length only; no power state exists here
					isd_pkg::OP_POWER_DOWN: s_d.pc.ip = next_ip;
					default: s_d.pc.ip = next_ip;
				endcase
			end
		end
	end

	// ==========================================================
	// State register
	always_ff @(posedge clk) begin
		if (rst) begin
			s_q <= isd_pkg::RST_STATE;
		end else begin
			s_q <= s_d;
		end
	end

	assign pc = s_q.pc;
	assign flags = s_q.fl;
	assign muldiv_result_reg = s_q.prod;
	assign dbg_data = s_q.dbg;
	assign ext = s_q.ext;
	assign stack_depth = s_q.sp;

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	len_step_a: assert property (
		ins_valid && (grp == isd_pkg::GRP_ARITH || grp == isd_pkg::GRP_CMP)
		|=> pc.ip == $past(pc.ip) + isd_pkg::ins_len($past(op)))
		else $error("Program counter did not advance by instruction length");

	add_word_a: assert property (
		ins_valid && op == 8'h00 |=> s_q.general_register[$past(ins.rd)] == $past(ra) + $past(rb))
		else $error("Word add result wrong");

	mul_unsigned_a: assert property (
		ins_valid && op == isd_pkg::OP_MULTIPLY_U
		|=> muldiv_result_reg == {16'h0000, $past(ra)} * {16'h0000, $past(rb)})
		else $error("Unsigned product wrong");

	div_zero_a: assert property (
		ins_valid && rb == 16'h0000
		&& (op == isd_pkg::OP_DIVIDE_S || op == isd_pkg::OP_DIVIDE_U
		|| op == isd_pkg::OP_LONG_DIVIDE_S || op == isd_pkg::OP_LONG_DIVIDE_U)
		|=> flags.v && muldiv_result_reg == $past(muldiv_result_reg))
		else $error("Divide by zero not flagged");

	bit_cmp_keep_a: assert property (
		ins_valid && op == isd_pkg::OP_BIT_COMPARE |=> s_q.general_register == $past(s_q.general_register))
		else $error("Bit compare changed a register");

	cmp_dec_a: assert property (
		ins_valid && grp == isd_pkg::GRP_CMP && !op[1] && op[0]
		|=> s_q.general_register[$past(ins.rd)] == $past(ra) - 16'h0002)
		else $error("Compare-decrement by two wrong");

	cmp_inc_a: assert property (
		ins_valid && grp == isd_pkg::GRP_CMP && op[1] && !op[0]
		|=> s_q.general_register[$past(ins.rd)] == $past(ra) + 16'h0001)
		else $error("Compare-increment by one wrong");

	jump_clear_a: assert property (
		ins_valid && op == isd_pkg::OP_IF_ONE_CLR && s_q.general_register[ins.rd][ins.rs]
		|=> pc.ip == $past(pc.ip) + 16'h0004 + $past(ins.imm)
		&& !s_q.general_register[$past(ins.rd)][$past(ins.rs)])
		else $error("Jump-and-clear missed branch or bit");

	ctx_switch_a: assert property (
		ins_valid && op == isd_pkg::OP_CONTEXT
		|=> s_q.general_register[$past(ins.rd)] == $past(ins.imm)
		&& s_q.stk[$past(stack_depth)] == $past(ra)
		&& stack_depth == $past(stack_depth) + 3'h1)
		else $error("Context switch push or load wrong");

	ret_restore_a: assert property (
		ins_valid && op == isd_pkg::OP_NEAR_RETURN
		|=> pc.ip == s_q.stk[stack_depth] && stack_depth == $past(stack_depth) - 3'h1)
		else $error("Near return did not restore the address");

	trap_entry_a: assert property (
		ins_valid && op == isd_pkg::OP_TRAP
		|=> pc.ip == {7'h00, $past(ins.rs[2:0]), $past(ins.rd), 2'b00}
		&& stack_depth == $past(stack_depth) + 3'h3)
		else $error("Trap entry wrong");

	power_nop_a: assert property (
		ins_valid && op == isd_pkg::OP_POWER_DOWN
		|=> s_q.general_register == $past(s_q.general_register) && flags == $past(flags)
		&& stack_depth == $past(stack_depth) && pc.ip == $past(pc.ip) + 16'h0004)
		else $error("Power-down opcode had an effect");

	prefix_end_a: assert property (
		ins_valid && grp != isd_pkg::GRP_PREFIX && ext.left == 3'h1
		|=> ext == '0)
		else $error("Prefix outlived its count");

	far_call_c: cover property (ins_valid && op == isd_pkg::OP_FAR_CALL);
	return_pop_c: cover property (ins_valid && op == isd_pkg::OP_NEAR_RETURN_POP);
	long_div_c: cover property (ins_valid && op == isd_pkg::OP_LONG_DIVIDE_S && rb != 16'h0000);
	sign_div_c: cover property (ins_valid && op == isd_pkg::OP_DIVIDE_S && rb != 16'h0000);
	page_prefix_c: cover property (ext.page_en && ext.left == 3'h2);
endmodule // isd_core

/* sim/tb.sv */
/*
 Self-checking bench of the instruction execute core, one task per scenario.
 Assumes isd_pkg and the core are compiled first; inputs change at the falling edge.
*/
`timescale 1ns/10ps
module tb;
	// ==========================================================
	// Stimulus and observed signals
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic ins_valid = 1'b0;
	isd_pkg::isd_ins_t ins = '0;
	logic [3:0] dbg_sel = 4'h0;
	isd_pkg::isd_pc_t pc;
	isd_pkg::isd_flags_t flags;
	logic [31:0] muldiv_result_reg;
	logic [15:0] dbg_data;
	isd_pkg::isd_ext_t ext;
	logic [2:0] stack_depth;
	int mismatches = 0;
	int cmp_count = 0;
	logic [15:0] ip_e = 16'h0000;
	logic [7:0] seg_e = 8'h00;
	logic [2:0] sp_e = 3'h0;
	logic pc_free = 1'b0;

	always #25 clk = ~clk;

	isd_core dut (
		.clk(clk),
		.rst(rst),
		.ins_valid(ins_valid),
		.ins(ins),
		.dbg_sel(dbg_sel),
		.pc(pc),
		.flags(flags),
		.muldiv_result_reg(muldiv_result_reg),
		.dbg_data(dbg_data),
		.ext(ext),
		.stack_depth(stack_depth)
	);

	// ==========================================================
	// Shared tasks
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic conclude;
		if (mismatches == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// One instruction, held for a single edge; the length is worked out here, not by the core
	task automatic exec(input logic [7:0] op, input logic [3:0] rs, input logic [3:0] rd,
			input logic [15:0] imm);
		logic four;
		four = (op[7:5] == 3'h4) || (op[4] && (op[7:5] inside {3'h0, 3'h1, 3'h2, 3'h7}));
		@(negedge clk);
		ins_valid = 1'b1;
		ins = {imm, rs, rd, op};
		@(negedge clk);
		ins_valid = 1'b0;
		ip_e = ip_e + (four ? 16'h0004 : 16'h0002);
		if (!pc_free)
			chk("pc", pc, {seg_e, ip_e});
	endtask

	// The debug copy lags by one edge, so one extra cycle is spent per read
	task automatic rdg(input logic [3:0] r, output logic [15:0] v);
		dbg_sel = r;
		@(negedge clk);
		v = dbg_data;
	endtask

	task automatic setr(input logic [3:0] r, input logic [15:0] v);
		exec(8'h8F, 4'h0, r, v);
		sp_e = sp_e + 3'h1;
		chk("depth", stack_depth, sp_e);
	endtask

	task automatic opchk(input logic [7:0] op, input logic [3:0] rs, input logic [3:0] rd,
			input logic [15:0] imm, input logic [15:0] exp);
		logic [15:0] v;
		exec(op, rs, rd, imm);
		rdg(rd, v);
		chk("gpr", v, exp);
	endtask

	task automatic mdchk(input logic [7:0] op, input logic [3:0] rs, input logic [3:0] rd,
			input logic [31:0] exp);
		exec(op, rs, rd, 16'h0000);
		chk("muldiv", muldiv_result_reg, exp);
	endtask

	task automatic go(input logic [7:0] op, input logic [3:0] rs, input logic [3:0] rd,
			input logic [15:0] imm, input logic [23:0] tgt, input logic [2:0] dsp);
		pc_free = 1'b1;
		exec(op, rs, rd, imm);
		{seg_e, ip_e} = tgt;
		sp_e = sp_e + dsp;
		chk("pc", pc, tgt);
		chk("depth", stack_depth, sp_e);
		pc_free = 1'b0;
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_reset;
		chk("pc", pc, 24'h00_0000);
		chk("flags", flags, 4'h0);
		chk("muldiv", muldiv_result_reg, 32'h0000_0000);
		chk("ext", ext, 25'h000_0000);
		chk("depth", stack_depth, 3'h0);
	endtask

	// Carry chains only hold if nothing flag-changing sits between the steps
	task automatic t_arith;
		setr(4'h1, 16'hFFFF);
		setr(4'h2, 16'h0001);
		setr(4'h4, 16'h12FF);
		opchk(8'h00, 4'h2, 4'h1, 16'h0000, 16'h0000);
		chk("flags", flags, 4'h5);
		opchk(8'h02, 4'h2, 4'h3, 16'h0000, 16'h0002);
		opchk(8'h14, 4'h0, 4'h3, 16'h0005, 16'hFFFD);
		chk("flags", flags, 4'hC);
		opchk(8'h16, 4'h0, 4'h3, 16'h0001, 16'hFFFB);
		opchk(8'h08, 4'h2, 4'h4, 16'h0000, 16'h1200);
	endtask

	task automatic t_muldiv;
		setr(4'h1, 16'hFFFE);
		setr(4'h2, 16'h0003);
		setr(4'h7, 16'h0004);
		setr(4'h8, 16'h0100);
		setr(4'h9, 16'h0000);
		mdchk(8'h60, 4'h2, 4'h1, 32'hFFFF_FFFA);
		mdchk(8'h64, 4'h2, 4'h0, 32'h0000_FFFE);
		mdchk(8'h60, 4'h2, 4'h1, 32'hFFFF_FFFA);
		mdchk(8'h62, 4'h2, 4'h0, 32'h0000_FFFE);
		mdchk(8'h61, 4'h2, 4'h1, 32'h0002_FFFA);
		mdchk(8'h61, 4'h8, 4'h8, 32'h0001_0000);
		mdchk(8'h65, 4'h7, 4'h0, 32'h0000_4000);
		mdchk(8'h63, 4'h7, 4'h0, 32'h0000_1000);
		mdchk(8'h63, 4'h9, 4'h0, 32'h0000_1000);
		chk("v", flags.v, 1'b1);
	endtask

	task automatic t_unary;
		logic [7:0] sop [5] = '{8'h6B, 8'h6C, 8'h6D, 8'h6E, 8'h6F};
		logic [15:0] sexp [5] = '{16'h4210, 16'h0842, 16'h4218, 16'h1842, 16'hF842};
		setr(4'h1, 16'h1234);
		setr(4'h3, 16'h0004);
		opchk(8'h66, 4'h0, 4'h1, 16'h0000, 16'hEDCB);
		opchk(8'h67, 4'h0, 4'h1, 16'h0000, 16'hED34);
		opchk(8'h68, 4'h0, 4'h1, 16'h0000, 16'h12CC);
		opchk(8'h69, 4'h0, 4'h1, 16'h0000, 16'h1234);
		opchk(8'h6A, 4'h1, 4'h2, 16'h0000, 16'h0003);
		for (int i = 0; i < 5; i++) begin
			setr(4'h4, 16'h8421);
			opchk(sop[i], 4'h3, 4'h4, 16'h0000, sexp[i]);
		end
		opchk(8'h50, 4'h0, 4'h5, 16'h0085, 16'hFF85);
		opchk(8'h51, 4'h0, 4'h5, 16'h0085, 16'h0085);
		opchk(8'h41, 4'h4, 4'h5, 16'h0000, 16'h0042);
	endtask

	task automatic t_bits;
		setr(4'h1, 16'h0001);
		setr(4'h2, 16'h0000);
		opchk(8'h80, 4'h1, 4'h2, 16'h0003, 16'h0008);
		opchk(8'h81, 4'h1, 4'h2, 16'h0003, 16'h0000);
		opchk(8'h83, 4'h1, 4'h2, 16'h0005, 16'h0020);
		opchk(8'h82, 4'h1, 4'h2, 16'h0015, 16'h0000);
		opchk(8'h84, 4'h1, 4'h2, 16'h0006, 16'h0040);
		opchk(8'h85, 4'h1, 4'h2, 16'h0006, 16'h0040);
		chk("flags", flags, 4'h6);
		opchk(8'h86, 4'h0, 4'h2, 16'hA5F0, 16'hA040);
		opchk(8'h87, 4'h0, 4'h2, 16'h5C0F, 16'hA04C);
	endtask

	task automatic t_cmp;
		setr(4'h1, 16'h0010);
		setr(4'h2, 16'h0010);
		opchk(8'h20, 4'h2, 4'h1, 16'h0000, 16'h000F);
		chk("z", flags.z, 1'b1);
		opchk(8'h31, 4'h0, 4'h1, 16'h0005, 16'h000D);
		opchk(8'h22, 4'h2, 4'h1, 16'h0000, 16'h000E);
		opchk(8'h33, 4'h0, 4'h1, 16'h0005, 16'h0010);
	endtask

	task automatic t_branch;
		logic [15:0] v;
		logic [15:0] ret;
		isd_pkg::isd_flags_t fl;
		logic [31:0] prod_old;
		setr(4'h1, 16'h0004);
		setr(4'h5, 16'h5555);
		go(8'h88, 4'h2, 4'h1, 16'h0010, {seg_e, ip_e + 16'h0014}, 3'h0);
		go(8'h8A, 4'h2, 4'h1, 16'h0010, {seg_e, ip_e + 16'h0004}, 3'h0);
		go(8'h89, 4'h2, 4'h1, 16'h0020, {seg_e, ip_e + 16'h0024}, 3'h0);
		rdg(4'h1, v);
		chk("bit", v, 16'h0000);
		go(8'h88, 4'h2, 4'h1, 16'h0010, {seg_e, ip_e + 16'h0004}, 3'h0);
		go(8'h8B, 4'h2, 4'h1, 16'h0030, {seg_e, ip_e + 16'h0034}, 3'h0);
		rdg(4'h1, v);
		chk("bit", v, 16'h0004);
		go(8'h8C, 4'h1, 4'h2, 16'h0100, 24'h12_0100, 3'h0);
		ret = ip_e + 16'h0004;
		go(8'h8D, 4'h3, 4'h4, 16'h0200, 24'h34_0200, 3'h2);
		go(8'hA0, 4'h0, 4'h0, 16'h0000, {8'h34, ret}, 3'h7);
		ret = ip_e + 16'h0004;
		go(8'h8E, 4'h0, 4'h5, 16'h0300, 24'h34_0300, 3'h2);
		go(8'hA1, 4'h0, 4'h6, 16'h0000, {8'h34, ret}, 3'h6);
		rdg(4'h6, v);
		chk("pop", v, 16'h5555);
		go(8'hA2, 4'h0, 4'h5, 16'h0000, 24'h00_0014, 3'h3);
		fl = flags;
		prod_old = muldiv_result_reg;
		exec(8'h90, 4'h3, 4'h3, 16'hFFFF);
		chk("flags", flags, fl);
		chk("muldiv", muldiv_result_reg, prod_old);
		chk("depth", stack_depth, sp_e);
	endtask

	task automatic t_prefix;
		setr(4'h1, 16'h1357);
		for (int k = 0; k < 6; k++) begin
			exec({5'b11110, k[2:0]}, 4'h0, 4'h1, 16'h0ABC);
			chk("ext", ext, {3'h2, k == 0, k[0], k inside {2, 3}, k[2], 16'h0ABC});
			exec(8'hA3, 4'h0, 4'h0, 16'h0000);
			chk("left", ext.left, 3'h1);
			exec(8'hA3, 4'h0, 4'h0, 16'h0000);
			chk("left", ext.left, 3'h0);
		end
		exec(8'hF4, 4'h0, 4'h3, 16'h0001);
		chk("left", ext.left, 3'h4);
		exec(8'hE0, 4'h1, 4'h0, 16'h0000);
		chk("ext", ext, {3'h1, 4'b1000, 16'h1357});
		exec(8'hA3, 4'h0, 4'h0, 16'h0000);
		chk("ext", ext, 23'h00_0000);
	endtask

	// A reset in mid-run must leave no trace of earlier state
	task automatic t_rerun;
		logic [15:0] v;
		@(negedge clk);
		rst = 1'b1;
		repeat (2) @(negedge clk);
		rst = 1'b0;
		ip_e = 16'h0000;
		seg_e = 8'h00;
		sp_e = 3'h0;
		t_reset();
		rdg(4'h7, v);
		chk("gpr", v, 16'h0000);
		exec(8'hA3, 4'h0, 4'h0, 16'h0000);
	endtask

	// ==========================================================
	// Main sequence and watchdog
	initial begin
		repeat (12) @(negedge clk);
		rst = 1'b0;
		t_reset();
		t_arith();
		t_muldiv();
		t_unary();
		t_bits();
		t_cmp();
		t_branch();
		t_prefix();
		t_rerun();
		conclude();
	end

	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		conclude();
	end
endmodule // tb
